// ===== rtl/dtc_timer_pair.sv
// dual 16-bit timer/counter with ahb-lite register slave
// Function
// R1: timer function counts once per machine cycle of six oscillator periods.
// R2: counter function samples the count pin each machine cycle, counts falling edges.
// R3: edge is high sample then low sample; count shows the following machine cycle.
// R4: edge recognition spans two machine cycles, so max rate is oscillator/12.
// R5: outside source holds each count pin level at least one machine cycle.
// R6: mode register resets to zero; fields gate, function, mode per timer.
// R7: with gate set, count only while irq pin high and run set.
// R8: function bit clear counts machine cycles, set counts count-pin edges.
// R9: mode 0 is a 5-bit prescaler in low byte feeding the high byte.
// R10: mode 1 cascades low and high bytes as one 16-bit counter.
// R11: mode 2 counts low byte, reloads it from high byte on overflow.
// R12: timer 0 mode 3 splits into low counter and high timer on timer 1 bits.
// R13: timer 1 in mode 3 stops and holds its count.
// R14: control register resets to zero; overflow, run, irq flag and type bits.
// R15: overflow flag set by hardware, cleared by vector acknowledge or software.
// R16: run bits are written only by software and switch counting.
// R17: external irq flag set on chosen edge or low level, cleared on service.
// R18: irq type bit selects falling edge or low level trigger.
// R19: rollover from all ones to zero sets the overflow flag.
// R20: setting run leaves the count unchanged.
// R21: split high byte uses timer 1 run bit and sets timer 1 overflow flag.
// R22: count bytes are software readable and writable, a write loads directly.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`include "dtc_params.svh"

module dtc_timer_pair
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic count_input_zero_pin,
  input wire logic count_input_one_pin,
  input wire logic ext_irq_zero_pin,
  input wire logic ext_irq_one_pin,
  input wire logic ack_timer_zero,
  input wire logic ack_timer_one,
  input wire logic ack_ext_irq_zero,
  input wire logic ack_ext_irq_one,
  output logic timer_zero_overflow_flag,
  output logic timer_one_overflow_flag,
  output logic ext_irq_zero_flag,
  output logic ext_irq_one_flag
);

  localparam logic [2:0] MC_LAST = 3'(`DTC_MCYCLE_CLKS - 1);

  logic [2:0] mc_cnt_r;
  logic mc_tick;
  dtc_pkg::dtc_pins_s sync1_r;
  dtc_pkg::dtc_pins_s sync2_r;
  dtc_pkg::dtc_pins_s samp_r;
  dtc_pkg::dtc_pins_s prev_r;
  dtc_pkg::dtc_pins_s fall;
  logic [7:0] mode_cfg_r;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] cnt0_lo_r;
  logic [7:0] cnt0_hi_r;
  logic [7:0] cnt1_lo_r;
  logic [7:0] cnt1_hi_r;
  dtc_pkg::dtc_cfg_s cfg0;
  dtc_pkg::dtc_cfg_s cfg1;
  logic split0;
  logic en0;
  logic en1;
  logic step0;
  logic step1;
  logic step0_hi;
  logic [16:0] res0;
  logic [16:0] res1;
  logic ovf0_set;
  logic ovf1_set;
  logic irq0_set;
  logic irq1_set;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic wr_pend_r;
  logic rd_pend_r;
  logic hit_r;
  logic [7:0] idx_r;
  logic [31:0] hrdata_r;
  logic accept;
  logic wr_act;
  logic wr_ctrl;
  logic [7:0] rd_mux;

  // one increment of a timer in modes 0..2; split mode steps the low byte alone
  function automatic logic [16:0] step_count(
    input dtc_pkg::dtc_mode_e m,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [16:0] res;
    logic [5:0] pre;
    begin
      res = {1'b0, hi, lo};
      pre = {1'b0, lo[4:0]} + 6'h01;
      unique case (m)
        dtc_pkg::DTC_MODE_13B:
        begin
          // upper three bits of the low byte are left alone
          res = {pre[5] & (hi == 8'hFF), pre[5] ? 8'(hi + 8'h01) : hi, lo[7:5], pre[4:0]};
        end
        dtc_pkg::DTC_MODE_16B:
        begin
          res = {1'b0, hi, lo} + 17'h00001;
        end
        dtc_pkg::DTC_MODE_RELOAD:
        begin
          res = {lo == 8'hFF, hi, (lo == 8'hFF) ? hi : 8'(lo + 8'h01)};
        end
        dtc_pkg::DTC_MODE_SPLIT:
        begin
          res = {lo == 8'hFF, hi, 8'(lo + 8'h01)};
        end
      endcase
      return res;
    end
  endfunction

  // machine cycle divider
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      mc_cnt_r <= 3'h0;
    else if (mc_tick)
      mc_cnt_r <= 3'h0;
    else
      mc_cnt_r <= mc_cnt_r + 3'h1;
  end

  assign mc_tick = (mc_cnt_r == MC_LAST); // see R1

  // pins come from outside; two flops before anything looks at them
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
    end
    else
    begin
      sync1_r <= {ext_irq_one_pin, ext_irq_zero_pin, count_input_one_pin, count_input_zero_pin};
      sync2_r <= sync1_r;
    end
  end

  // one sample per machine cycle; reset high so no edge is invented at start
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      samp_r <= 4'hF;
      prev_r <= 4'hF;
    end
    else if (mc_tick)
    begin
      samp_r <= sync2_r; // see R2
      prev_r <= samp_r;
    end
  end

  // an edge seen between two samples is counted at the next machine cycle
  assign fall = prev_r & ~samp_r; // see R3, R4

  assign cfg0 = dtc_pkg::dtc_cfg_s'(mode_cfg_r[`DTC_CFG0_MSB:`DTC_CFG0_LSB]);
  assign cfg1 = dtc_pkg::dtc_cfg_s'(mode_cfg_r[`DTC_CFG1_MSB:`DTC_CFG1_LSB]);
  assign split0 = (cfg0.mode == dtc_pkg::DTC_MODE_SPLIT);

  // gate from the irq pin only matters when the gate bit is set
  assign en0 = ctrl_r[`DTC_RUN0_BIT] & (~cfg0.gate | samp_r.ext_irq_zero_pin); // see R7, R16
  assign en1 = ctrl_r[`DTC_RUN1_BIT] & (~cfg1.gate | samp_r.ext_irq_one_pin); // see R7, R16
  // source is the machine cycle or a recognised count-pin edge
  assign step0 = mc_tick & en0 & (~cfg0.func | fall.count_input_zero_pin); // see R1, R2, R8
  assign step1 = mc_tick & en1 & (~cfg1.func | fall.count_input_one_pin) // see R8
    & (cfg1.mode != dtc_pkg::DTC_MODE_SPLIT); // see R13
  // split high byte is a plain timer on timer 1 run, no gate
  assign step0_hi = mc_tick & split0 & ctrl_r[`DTC_RUN1_BIT]; // see R12, R21

  assign res0 = step_count(cfg0.mode, cnt0_lo_r, cnt0_hi_r); // see R9, R10, R11, R12
  assign res1 = step_count(cfg1.mode, cnt1_lo_r, cnt1_hi_r); // see R9, R10, R11

  assign ovf0_set = step0 & res0[16]; // see R19
  // while split, timer 1 overflow no longer reaches its flag
  assign ovf1_set = split0 ? (step0_hi & (cnt0_hi_r == 8'hFF)) : (step1 & res1[16]); // see R21
  assign irq0_set = mc_tick & (ctrl_r[`DTC_ITYP0_BIT] ? fall.ext_irq_zero_pin // see R17, R18
    : ~samp_r.ext_irq_zero_pin);
  assign irq1_set = mc_tick & (ctrl_r[`DTC_ITYP1_BIT] ? fall.ext_irq_one_pin // see R17, R18
    : ~samp_r.ext_irq_one_pin);

  // ahb-lite slave: writes zero wait, reads one wait state so hrdata is a flop
  assign accept = hsel & htrans[1] & hready;
  assign wr_act = wr_pend_r & hit_r;
  assign wr_ctrl = wr_act & (idx_r == `DTC_IDX_CTRL);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hit_r <= 1'b0;
      idx_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= accept & hwrite;
      rd_pend_r <= accept & ~hwrite;
      if (accept)
      begin
        hit_r <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
        idx_r <= haddr[9:2];
      end
    end
  end

  always_comb
  begin
    rd_mux = 8'h00;
    if (hit_r)
    begin
      unique case (idx_r)
        `DTC_IDX_CTRL: rd_mux = ctrl_r;
        `DTC_IDX_MODE: rd_mux = mode_cfg_r;
        `DTC_IDX_CNT0_LO: rd_mux = cnt0_lo_r; // see R22
        `DTC_IDX_CNT0_HI: rd_mux = cnt0_hi_r; // see R22
        `DTC_IDX_CNT1_LO: rd_mux = cnt1_lo_r; // see R22
        `DTC_IDX_CNT1_HI: rd_mux = cnt1_hi_r; // see R22
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      hrdata_r <= 32'h00000000;
    else if (rd_pend_r)
      hrdata_r <= {24'h000000, rd_mux};
  end

  assign hreadyout = ~rd_pend_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // mode register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      mode_cfg_r <= `DTC_RST_MODE; // see R6
    else if (wr_act && (idx_r == `DTC_IDX_MODE))
      mode_cfg_r <= hwdata[7:0]; // see R6
  end

  // hardware sets win over software writes and acknowledges in the same cycle
  assign set_vec = {ovf1_set, 1'b0, ovf0_set, 1'b0, irq1_set, 1'b0, irq0_set, 1'b0};
  assign clr_vec = {ack_timer_one, 1'b0, ack_timer_zero, 1'b0,
    ack_ext_irq_one, 1'b0, ack_ext_irq_zero, 1'b0};
  assign ctrl_nxt = ((wr_ctrl ? hwdata[7:0] : ctrl_r) & ~clr_vec) | set_vec; // see R15, R17

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      ctrl_r <= `DTC_RST_CTRL; // see R14
    else
      ctrl_r <= ctrl_nxt; // see R14, R16
  end

  assign timer_zero_overflow_flag = ctrl_r[`DTC_OVF0_BIT];
  assign timer_one_overflow_flag = ctrl_r[`DTC_OVF1_BIT];
  assign ext_irq_zero_flag = ctrl_r[`DTC_IRQF0_BIT];
  assign ext_irq_one_flag = ctrl_r[`DTC_IRQF1_BIT];

  // timer 0 count bytes; a software write beats a count in the same cycle
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt0_lo_r <= 8'h00;
      cnt0_hi_r <= 8'h00;
    end
    else
    begin
      if (wr_act && (idx_r == `DTC_IDX_CNT0_LO))
        cnt0_lo_r <= hwdata[7:0]; // see R22
      else if (step0)
        cnt0_lo_r <= res0[7:0];
      if (wr_act && (idx_r == `DTC_IDX_CNT0_HI))
        cnt0_hi_r <= hwdata[7:0]; // see R22
      else if (step0_hi)
        cnt0_hi_r <= cnt0_hi_r + 8'h01; // see R12
      else if (step0 && !split0)
        cnt0_hi_r <= res0[15:8];
    end
  end

  // timer 1 count bytes; run changes never touch them
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt1_lo_r <= 8'h00;
      cnt1_hi_r <= 8'h00;
    end
    else
    begin
      if (wr_act && (idx_r == `DTC_IDX_CNT1_LO))
        cnt1_lo_r <= hwdata[7:0]; // see R22
      else if (step1)
        cnt1_lo_r <= res1[7:0]; // see R20
      if (wr_act && (idx_r == `DTC_IDX_CNT1_HI))
        cnt1_hi_r <= hwdata[7:0]; // see R22
      else if (step1)
        cnt1_hi_r <= res1[15:8];
    end
  end

  default clocking dtc_cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  AST_TICK_SPACING: assert property ( // see R1
    mc_tick |=> !mc_tick [*5] ##1 mc_tick)
    else $error("machine cycle tick not every six clocks");

  AST_T0_TIMER16: assert property ( // see R10
    (mc_tick && en0 && !cfg0.func && cfg0.mode == dtc_pkg::DTC_MODE_16B && !wr_act)
    |=> ({cnt0_hi_r, cnt0_lo_r} == 16'($past({cnt0_hi_r, cnt0_lo_r}) + 16'h0001)))
    else $error("timer 0 did not step by one in 16-bit timer mode");

  AST_CNT_NO_EDGE: assert property ( // see R2
    (mc_tick && cfg0.func && !fall.count_input_zero_pin && !split0 && !wr_act)
    |=> $stable({cnt0_hi_r, cnt0_lo_r}))
    else $error("counter moved without a falling edge");

  AST_EDGE_COUNTS: assert property ( // see R3
    (mc_tick && en0 && cfg0.func && fall.count_input_zero_pin
      && cfg0.mode == dtc_pkg::DTC_MODE_16B && !wr_act)
    |=> ({cnt0_hi_r, cnt0_lo_r} == 16'($past({cnt0_hi_r, cnt0_lo_r}) + 16'h0001)))
    else $error("recognised edge was not counted");

  AST_GATE_HOLD: assert property ( // see R7
    (mc_tick && cfg0.gate && !samp_r.ext_irq_zero_pin && !split0 && !wr_act)
    |=> $stable({cnt0_hi_r, cnt0_lo_r}))
    else $error("gated timer counted with irq pin low");

  AST_RELOAD: assert property ( // see R11
    (step0 && cfg0.mode == dtc_pkg::DTC_MODE_RELOAD && cnt0_lo_r == 8'hFF && !wr_act)
    |=> (cnt0_lo_r == $past(cnt0_hi_r)) && ctrl_r[`DTC_OVF0_BIT])
    else $error("mode 2 reload or flag missing");

  AST_T1_STOP: assert property ( // see R13
    (cfg1.mode == dtc_pkg::DTC_MODE_SPLIT && !wr_act) |=> $stable({cnt1_hi_r, cnt1_lo_r}))
    else $error("timer 1 moved in mode 3");

  AST_OVF_SET: assert property ( // see R15
    ovf0_set |=> ctrl_r[`DTC_OVF0_BIT])
    else $error("overflow flag lost against a clear");

  AST_SPLIT_HIGH: assert property ( // see R21
    (step0_hi && cnt0_hi_r == 8'hFF && !wr_act) |=> (cnt0_hi_r == 8'h00)
      && ctrl_r[`DTC_OVF1_BIT])
    else $error("split high byte overflow did not set timer 1 flag");

  AST_IE_LEVEL: assert property ( // see R17
    (mc_tick && !ctrl_r[`DTC_ITYP0_BIT] && !samp_r.ext_irq_zero_pin) |=> ctrl_r[`DTC_IRQF0_BIT])
    else $error("low level did not set irq 0 flag");

  AST_RUN_SW: assert property ( // see R16
    !wr_ctrl |=> $stable({ctrl_r[`DTC_RUN1_BIT], ctrl_r[`DTC_RUN0_BIT]}))
    else $error("run bit changed without a software write");

endmodule // dtc_timer_pair

// ===== rtl/dtc_params.svh
// register indices, field positions, reset values and timing counts of the timer pair
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// register indices; byte address is four times the index
`define DTC_IDX_CTRL 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_CNT0_LO 8'h8A
`define DTC_IDX_CNT1_LO 8'h8B
`define DTC_IDX_CNT0_HI 8'h8C
`define DTC_IDX_CNT1_HI 8'h8D

`define DTC_RST_CTRL 8'h00
`define DTC_RST_MODE 8'h00

// control register fields
`define DTC_OVF1_BIT 7
`define DTC_RUN1_BIT 6
`define DTC_OVF0_BIT 5
`define DTC_RUN0_BIT 4
`define DTC_IRQF1_BIT 3
`define DTC_ITYP1_BIT 2
`define DTC_IRQF0_BIT 1
`define DTC_ITYP0_BIT 0

// mode register fields
`define DTC_CFG1_MSB 7
`define DTC_CFG1_LSB 4
`define DTC_CFG0_MSB 3
`define DTC_CFG0_LSB 0

// machine cycle length in oscillator periods; clk_sys is the oscillator
`define DTC_MCYCLE_OSC 6
`define DTC_MCYCLE_CLKS (`DTC_MCYCLE_OSC)

`endif

// ===== rtl/dtc_pkg.sv
// types shared by the timer pair
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_13B = 2'b00,
    DTC_MODE_16B = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_e;

  // one nibble of the mode register
  typedef struct packed {
    logic gate;
    logic func;
    dtc_mode_e mode;
  } dtc_cfg_s;

  // pins as seen after synchronisation, bit order fixed by this struct
  typedef struct packed {
    logic ext_irq_one_pin;
    logic ext_irq_zero_pin;
    logic count_input_one_pin;
    logic count_input_zero_pin;
  } dtc_pins_s;

endpackage

// ===== dv/dtc_pin_source.sv
// stand-in for the external count and gate pin drivers
`timescale 1ns/10ps
module dtc_pin_source
(
  input wire logic clk_sys,
  input wire logic start,
  input wire logic which,
  input wire logic [7:0] pulses,
  input wire logic [3:0] hold,
  input wire logic [1:0] irq_lvl,
  output dtc_pkg::dtc_pins_s pins
);
  int left = 0;
  int tick = 0;
  logic low;

  // each level stands hold machine cycles; hold of zero is never commanded
  always @(posedge clk_sys)
  begin
    if (start)
    begin
      left <= 2 * pulses;
      tick <= 0;
    end
    else if (left > 0)
    begin
      if (tick == 6 * hold - 1)
      begin
        tick <= 0;
        left <= left - 1;
      end
      else
        tick <= tick + 1;
    end
  end

  assign low = (left > 0) && (left % 2 == 0);
  assign pins = {irq_lvl, ~(low & which), ~(low & ~which)};
endmodule // dtc_pin_source

// ===== dv/test_dual_timer_counter_pair.sv
// self-checking bench of the timer pair over ahb-lite
`timescale 1ns/10ps
`include "dtc_params.svh"
module test_dual_timer_counter_pair;
  logic clk_sys;
  logic resetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] ack = 4'h0;
  logic [3:0] flag;
  logic start = 1'b0;
  logic which = 1'b0;
  logic [7:0] pulses = 8'h0;
  logic [3:0] hold = 4'h1;
  logic [1:0] irq_lvl = 2'h3;
  logic [31:0] rd;
  dtc_pkg::dtc_pins_s pins;
  int errors = 0;
  int checked = 0;
  int n;

  dtc_timer_pair dtc_timer_pair_i (.clk_sys(clk_sys), .resetn(resetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .count_input_zero_pin(pins.count_input_zero_pin),
    .count_input_one_pin(pins.count_input_one_pin),
    .ext_irq_zero_pin(pins.ext_irq_zero_pin), .ext_irq_one_pin(pins.ext_irq_one_pin),
    .ack_timer_zero(ack[0]), .ack_timer_one(ack[1]), .ack_ext_irq_zero(ack[2]),
    .ack_ext_irq_one(ack[3]), .timer_zero_overflow_flag(flag[0]),
    .timer_one_overflow_flag(flag[1]), .ext_irq_zero_flag(flag[2]),
    .ext_irq_one_flag(flag[3]));

  dtc_pin_source dtc_pin_source_i (.clk_sys(clk_sys), .start(start), .which(which),
    .pulses(pulses), .hold(hold), .irq_lvl(irq_lvl), .pins(pins));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      errors++;
      $display("wrong value at %0t: got %h, want %h..%h", $time, got, lo, hi);
    end
  endtask

  // ready and read data are sampled half a cycle ahead of the edge, away from the race
  task automatic wait_rdy;
    logic rdy;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge clk_sys);
      n++;
    end
    while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1)
    begin
      errors++;
      $display("wrong value at %0t: bus hung", $time);
      close_out;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] lo, input logic [7:0] hi);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, lo}, {24'h0, hi});
    chk({31'h0, hresp}, 32'h0, 32'h0);
  endtask

  task automatic fchk(input logic [3:0] e);
    @(negedge clk_sys);
    chk({28'h0, flag}, {28'h0, e}, {28'h0, e});
    @(posedge clk_sys);
  endtask

  task automatic wait_flag(input int k, input int lim);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (flag[k] !== 1'b1 && n < lim);
    @(posedge clk_sys);
    if (flag[k] !== 1'b1)
    begin
      errors++;
      $display("wrong value at %0t: flag %0d never rose", $time, k);
      close_out;
    end
  endtask

  task automatic burst(input logic w, input logic [7:0] p, input logic [3:0] h);
    which <= w;
    pulses <= p;
    hold <= h;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rdc(`DTC_IDX_CTRL, 8'h00, 8'h00);
    rdc(`DTC_IDX_MODE, 8'h00, 8'h00);
    rdc(8'h90, 8'h00, 8'h00);
    wr(`DTC_IDX_MODE, 8'h5A);
    rdc(`DTC_IDX_MODE, 8'h5A, 8'h5A);
    $display("test registers done");
    wr(`DTC_IDX_MODE, 8'h01);
    wr(`DTC_IDX_CNT0_HI, 8'hFF);
    wr(`DTC_IDX_CNT0_LO, 8'hF0);
    rdc(`DTC_IDX_CNT0_LO, 8'hF0, 8'hF0);
    wr(`DTC_IDX_CTRL, 8'h10);
    wait_flag(0, 200);
    chk(32'(n), 32'd88, 32'd104);
    rdc(`DTC_IDX_CNT0_HI, 8'h00, 8'h00);
    wr(`DTC_IDX_CTRL, 8'h20);
    rdc(`DTC_IDX_CTRL, 8'h20, 8'h20);
    ack <= 4'h1;
    @(posedge clk_sys);
    ack <= 4'h0;
    fchk(4'h0);
    wr(`DTC_IDX_CNT0_LO, 8'h40);
    repeat (24) @(posedge clk_sys);
    rdc(`DTC_IDX_CNT0_LO, 8'h40, 8'h40);
    wr(`DTC_IDX_CTRL, 8'h10);
    rdc(`DTC_IDX_CNT0_LO, 8'h40, 8'h41);
    $display("test timer done");
    irq_lvl <= 2'h2;
    wr(`DTC_IDX_MODE, 8'h09);
    // the low gate level needs sync and a machine-cycle sample before it stops the count
    repeat (12) @(posedge clk_sys);
    wr(`DTC_IDX_CNT0_LO, 8'h00);
    wr(`DTC_IDX_CNT0_HI, 8'h00);
    repeat (60) @(posedge clk_sys);
    rdc(`DTC_IDX_CNT0_LO, 8'h00, 8'h00);
    irq_lvl <= 2'h3;
    repeat (60) @(posedge clk_sys);
    rdc(`DTC_IDX_CNT0_LO, 8'h08, 8'h0C);
    wr(`DTC_IDX_CTRL, 8'h00);
    $display("test gate done");
    wr(`DTC_IDX_MODE, 8'h60);
    wr(`DTC_IDX_CNT1_HI, 8'hFD);
    wr(`DTC_IDX_CNT1_LO, 8'hFD);
    wr(`DTC_IDX_CTRL, 8'h40);
    burst(1'b1, 8'd3, 4'd1);
    repeat (60) @(posedge clk_sys);
    rdc(`DTC_IDX_CNT1_LO, 8'hFD, 8'hFD);
    rdc(`DTC_IDX_CTRL, 8'hC0, 8'hC0);
    burst(1'b1, 8'd2, 4'd3);
    repeat (100) @(posedge clk_sys);
    rdc(`DTC_IDX_CNT1_LO, 8'hFF, 8'hFF);
    $display("test counter done");
    wr(`DTC_IDX_CTRL, 8'h00);
    wr(`DTC_IDX_MODE, 8'h05);
    wr(`DTC_IDX_CNT0_LO, 8'h00);
    wr(`DTC_IDX_CNT0_HI, 8'h00);
    wr(`DTC_IDX_CTRL, 8'h10);
    burst(1'b0, 8'd4, 4'd1);
    repeat (80) @(posedge clk_sys);
    rdc(`DTC_IDX_CNT0_LO, 8'h04, 8'h04);
    wr(`DTC_IDX_CTRL, 8'h00);
    wr(`DTC_IDX_MODE, 8'h02);
    wr(`DTC_IDX_CNT0_HI, 8'h80);
    wr(`DTC_IDX_CNT0_LO, 8'hFE);
    wr(`DTC_IDX_CTRL, 8'h10);
    wait_flag(0, 40);
    rdc(`DTC_IDX_CNT0_LO, 8'h80, 8'h81);
    $display("test timer zero modes done");
    wr(`DTC_IDX_CTRL, 8'h00);
    wr(`DTC_IDX_CNT1_LO, 8'h77);
    wr(`DTC_IDX_MODE, 8'h33);
    wr(`DTC_IDX_CNT0_LO, 8'h00);
    wr(`DTC_IDX_CNT0_HI, 8'hFE);
    wr(`DTC_IDX_CTRL, 8'h40);
    wait_flag(1, 40);
    rdc(`DTC_IDX_CNT0_LO, 8'h00, 8'h00);
    rdc(`DTC_IDX_CNT1_LO, 8'h77, 8'h77);
    $display("test split done");
    wr(`DTC_IDX_CTRL, 8'h00);
    wr(`DTC_IDX_MODE, 8'h00);
    wr(`DTC_IDX_CNT0_LO, 8'h1E);
    wr(`DTC_IDX_CNT0_HI, 8'h00);
    wr(`DTC_IDX_CTRL, 8'h10);
    repeat (30) @(posedge clk_sys);
    wr(`DTC_IDX_CTRL, 8'h00);
    rdc(`DTC_IDX_CNT0_HI, 8'h01, 8'h01);
    rdc(`DTC_IDX_CNT0_LO, 8'h01, 8'h06);
    $display("test prescaler done");
    wr(`DTC_IDX_CTRL, 8'h05);
    irq_lvl <= 2'h0;
    wait_flag(2, 40);
    wait_flag(3, 40);
    ack <= 4'hC;
    @(posedge clk_sys);
    ack <= 4'h0;
    repeat (30) @(posedge clk_sys);
    fchk(4'h0);
    wr(`DTC_IDX_CTRL, 8'h00);
    repeat (30) @(posedge clk_sys);
    fchk(4'hC);
    irq_lvl <= 2'h3;
    $display("test irq done");
    close_out;
  end
endmodule // test_dual_timer_counter_pair
